/* File: rtl/tcrb_timer.sv */
// Purpose: 16-bit timer/counter with capture, auto-reload and baud output
// Assumes: apb slave, 32-bit data, registers one per aligned word
// Notes:   pready follows one cycle into the access phase
//
// Behaviour
// - overflow sets overflow_flag unless a baud bit is set; software clears.
// - trigger capture or reload sets ext_edge_flag; software clears.
// - rx baud source bit picks this overflow, else timer1 overflow.
// - tx baud source bit picks this overflow, else timer1 overflow.
// - trigger edge acts only if pin enabled and both baud bits zero.
// - count advances only while run_control is one; otherwise holds, save for bus writes and trigger edge reloads.
// - timer mode advances count once every two system clocks.
// - counter mode advances count on each count pin falling edge.
// - reload mode loads reload value on overflow and on trigger edge.
// - capture mode copies count to reload registers on trigger edge.
// - with a baud source bit set, always auto-reload on overflow.
// - reload value held as low and high byte registers, reset zero.
// - count readable and writable as low and high bytes, reset zero.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "tcrb_consts.svh"

module tcrb_timer
	import tcrb_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        count_input_pin,
	input  wire logic        trigger_pin,
	input  wire logic        timer1_overflow,
	output logic             rx_baud_tick,
	output logic             tx_baud_tick,
	output logic             irq
);

	tcrb_state_t s;
	tcrb_state_t next_s;
	tcrb_edge_if ev ();

	logic [7:0] idx;
	logic       wr;
	logic       baud;
	logic       run;
	logic       inc;
	logic       ovf;
	logic       trig;
	logic       wr_cnt;

	// ------------------------------------------------------------------
	// pin front end
	// ------------------------------------------------------------------
	tcrb_pin_sync u_sync (
		.pclk            (pclk),
		.presetn         (presetn),
		.count_input_pin (count_input_pin),
		.trigger_pin     (trigger_pin),
		.ev              (ev.src)
	);

	// ------------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------------
	function automatic logic is_mapped(input logic [7:0] i);
		is_mapped = (i == `TCRB_IDX_CTRL)     || (i == `TCRB_IDX_RLD_LO) ||
		            (i == `TCRB_IDX_RLD_HI)   || (i == `TCRB_IDX_CNT_LO) ||
		            (i == `TCRB_IDX_CNT_HI)   || (i == `TCRB_IDX_IRQ_STAT) ||
		            (i == `TCRB_IDX_IRQ_MASK);
	endfunction

	function automatic logic [31:0] reg_read(input logic [7:0] i,
	                                         input tcrb_state_t st);
		reg_read = 32'h0000_0000;
		unique case (i)
			`TCRB_IDX_CTRL:     reg_read[7:0] = st.ctrl;
			`TCRB_IDX_RLD_LO:   reg_read[7:0] = st.reload[7:0];
			`TCRB_IDX_RLD_HI:   reg_read[7:0] = st.reload[15:8];
			`TCRB_IDX_CNT_LO:   reg_read[7:0] = st.count[7:0];
			`TCRB_IDX_CNT_HI:   reg_read[7:0] = st.count[15:8];
			`TCRB_IDX_IRQ_STAT: reg_read[1:0] = st.irq_stat;
			`TCRB_IDX_IRQ_MASK: reg_read[1:0] = st.irq_mask;
			default:            reg_read = 32'h0000_0000;
		endcase
	endfunction

	assign idx    = paddr[9:2];
	// a write lands at the edge where pready is seen high
	assign wr     = psel && penable && s.ack && pwrite && is_mapped(idx);
	assign wr_cnt = wr && ((idx == `TCRB_IDX_CNT_LO) ||
	                       (idx == `TCRB_IDX_CNT_HI));

	// ------------------------------------------------------------------
	// counting
	// ------------------------------------------------------------------
	assign baud = s.ctrl[`TCRB_B_RXSRC] || s.ctrl[`TCRB_B_TXSRC];
	assign run  = s.ctrl[`TCRB_B_RUN];
	// gated by run_control; prescale; pin edge
	assign inc  = run && (s.ctrl[`TCRB_B_CSRC] ? ev.count_fall :
	              (s.prescale == 1'(`TCRB_TIMER_DIV - 1)));
	assign ovf  = inc && (s.count == `TCRB_CNT_MAX);
	// pin enable and no baud source
	assign trig = s.ctrl[`TCRB_B_TRIGEN] && !baud && ev.trig_fall;

	always_comb
	begin
		next_s = s;

		// two system clocks per step, reset while stopped
		next_s.prescale = (run && !s.ctrl[`TCRB_B_CSRC]) ? ~s.prescale : 1'b0;

		if (inc)
			next_s.count = 16'(s.count + 16'h0001);
		// reload on overflow; forced when baud source set
		if (ovf && (baud || !s.ctrl[`TCRB_B_CAPSEL]))
			next_s.count = s.reload;
		if (trig && !s.ctrl[`TCRB_B_CAPSEL])
			next_s.count = s.reload;

		// bus write to the count wins over counting
		if (wr && idx == `TCRB_IDX_CNT_LO)
			next_s.count[7:0] = pwdata[7:0];
		if (wr && idx == `TCRB_IDX_CNT_HI)
			next_s.count[15:8] = pwdata[7:0];
		if (wr && idx == `TCRB_IDX_RLD_LO)
			next_s.reload[7:0] = pwdata[7:0];
		if (wr && idx == `TCRB_IDX_RLD_HI)
			next_s.reload[15:8] = pwdata[7:0];
		// capture beats a same-cycle bus write
		if (trig && s.ctrl[`TCRB_B_CAPSEL])
			next_s.reload = s.count;

		if (wr && idx == `TCRB_IDX_CTRL)
			next_s.ctrl = pwdata[7:0];
		// hardware sets, only software clears; set wins
		if (ovf && !baud)
			next_s.ctrl[`TCRB_B_OVF] = 1'b1;
		// set wins over a clearing write
		if (trig)
			next_s.ctrl[`TCRB_B_EXT] = 1'b1;

		// ------------------------------------------------------------
		// interrupt status: write one to clear, set wins
		// ------------------------------------------------------------
		if (wr && idx == `TCRB_IDX_IRQ_STAT)
			next_s.irq_stat = s.irq_stat & ~pwdata[1:0];
		if (wr && idx == `TCRB_IDX_IRQ_MASK)
			next_s.irq_mask = pwdata[1:0];
		if (ovf && !baud)
			next_s.irq_stat[`TCRB_I_OVF] = 1'b1;
		if (trig)
			next_s.irq_stat[`TCRB_I_EXT] = 1'b1;
		next_s.irq = |(next_s.irq_stat & next_s.irq_mask);

		next_s.rx_tick = s.ctrl[`TCRB_B_RXSRC] ? ovf : timer1_overflow;
		next_s.tx_tick = s.ctrl[`TCRB_B_TXSRC] ? ovf : timer1_overflow;

		// ------------------------------------------------------------
		// apb answer, one wait state
		// ------------------------------------------------------------
		next_s.ack = psel && penable && !s.ack;
		if (psel && penable && !s.ack)
		begin
			next_s.rdata  = pwrite ? 32'h0000_0000 : reg_read(idx, s);
			next_s.slverr = !is_mapped(idx);
		end
		else if (!psel)
		begin
			next_s.rdata  = 32'h0000_0000;
			next_s.slverr = 1'b0;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s          <= '0;
			s.ctrl     <= `TCRB_CTRL_RST;
			s.reload   <= `TCRB_WORD_RST;
			s.count    <= `TCRB_WORD_RST;
			s.irq_stat <= `TCRB_IRQ_RST;
			s.irq_mask <= `TCRB_IRQ_RST;
		end
		else
			s <= next_s;
	end

	assign prdata       = s.rdata;
	assign pready       = s.ack;
	assign pslverr      = s.slverr;
	assign rx_baud_tick = s.rx_tick;
	assign tx_baud_tick = s.tx_tick;
	assign irq          = s.irq;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	logic quiet;
	assign quiet = !wr_cnt && !ovf && !trig;

	sequence apb_start;
		psel && penable && !pready;
	endsequence
	sequence apb_done;
		pready;
	endsequence

	a_apb_ready: assert property (apb_start |=> apb_done)
		else $error("apb access not answered in one wait state");
	a_ovf_flag: assert property (ovf && !baud |=> s.ctrl[`TCRB_B_OVF])
		else $error("overflow flag not set");
	a_ovf_baud_quiet: assert property (baud && !s.ctrl[`TCRB_B_OVF] &&
		!(wr && idx == `TCRB_IDX_CTRL) |=> !s.ctrl[`TCRB_B_OVF])
		else $error("overflow flag set under baud use");
	a_ext_flag: assert property (trig |=> s.ctrl[`TCRB_B_EXT])
		else $error("edge flag not set");
	a_rx_source: assert property (s.ctrl[`TCRB_B_RXSRC] |=>
		rx_baud_tick == $past(ovf))
		else $error("rx baud not from timer overflow");
	a_tx_source: assert property (!s.ctrl[`TCRB_B_TXSRC] |=>
		tx_baud_tick == $past(timer1_overflow))
		else $error("tx baud not from timer1");
	a_pin_ignored: assert property (!s.ctrl[`TCRB_B_TRIGEN] && !wr &&
		!inc |=> $stable(s.count) && $stable(s.reload))
		else $error("disabled trigger pin acted");
	a_run_hold: assert property (!run && !wr_cnt && !trig |=>
		$stable(s.count))
		else $error("count moved while stopped");
	a_timer_rate: assert property (run && !s.ctrl[`TCRB_B_CSRC] &&
		quiet && $stable(s.ctrl) [*2] |=>
		s.count == 16'($past(s.count, 2) + 16'h0001))
		else $error("timer mode not one step per two clocks");
	a_counter_step: assert property (run && s.ctrl[`TCRB_B_CSRC] &&
		ev.count_fall && quiet |=> s.count == 16'($past(s.count) + 16'h0001))
		else $error("counter mode missed pin edge");
	a_reload_ovf: assert property (ovf && (baud ||
		!s.ctrl[`TCRB_B_CAPSEL]) && !wr_cnt |=> s.count == $past(s.reload))
		else $error("no reload on overflow");
	a_capture: assert property (trig && s.ctrl[`TCRB_B_CAPSEL] |=>
		s.reload == $past(s.count))
		else $error("capture missed");

	// ------------------------------------------------------------------
	// other baud sources, held flags and counts, writes, reloads, wrap and clear
	// ------------------------------------------------------------------
	a_rx_timer1: assert property (!s.ctrl[`TCRB_B_RXSRC] |=>
		rx_baud_tick == $past(timer1_overflow))
		else $error("rx baud not from timer1");
	a_tx_own: assert property (s.ctrl[`TCRB_B_TXSRC] |=>
		tx_baud_tick == $past(ovf))
		else $error("tx baud not from timer overflow");
	a_baud_no_capture: assert property (baud && !wr |=>
		$stable(s.reload))
		else $error("trigger pin acted under baud use");
	a_ext_only_trig: assert property (!trig && !s.ctrl[`TCRB_B_EXT] &&
		!(wr && idx == `TCRB_IDX_CTRL) |=> !s.ctrl[`TCRB_B_EXT])
		else $error("edge flag set without trigger");
	a_ovf_flag_hold: assert property (s.ctrl[`TCRB_B_OVF] &&
		!(wr && idx == `TCRB_IDX_CTRL) |=> s.ctrl[`TCRB_B_OVF])
		else $error("overflow flag cleared by hardware");
	a_ext_flag_hold: assert property (s.ctrl[`TCRB_B_EXT] &&
		!(wr && idx == `TCRB_IDX_CTRL) |=> s.ctrl[`TCRB_B_EXT])
		else $error("edge flag cleared by hardware");
	a_count_write: assert property (wr && idx == `TCRB_IDX_CNT_LO |=>
		s.count[7:0] == $past(pwdata[7:0]))
		else $error("count low byte write lost");
	a_reload_write: assert property (wr && idx == `TCRB_IDX_RLD_HI &&
		!trig |=> s.reload[15:8] == $past(pwdata[7:0]))
		else $error("reload high byte write lost");
	a_trig_reload: assert property (trig && !s.ctrl[`TCRB_B_CAPSEL] &&
		!wr_cnt |=> s.count == $past(s.reload))
		else $error("no reload on trigger edge");
	a_counter_idle: assert property (run && s.ctrl[`TCRB_B_CSRC] &&
		!ev.count_fall && quiet |=> $stable(s.count))
		else $error("counter mode stepped without pin edge");
	a_wrap_zero: assert property (ovf && !baud &&
		s.ctrl[`TCRB_B_CAPSEL] && !wr_cnt |=> s.count == 16'h0000)
		else $error("overflow did not wrap to zero");
	a_prescale_stop: assert property (!run |=>
		!s.prescale)
		else $error("prescaler ran while stopped");
	a_stat_clear: assert property (wr && idx == `TCRB_IDX_IRQ_STAT &&
		pwdata[`TCRB_I_OVF] && !(ovf && !baud) |=>
		!s.irq_stat[`TCRB_I_OVF])
		else $error("overflow status not cleared");

endmodule // tcrb_timer

`default_nettype wire

/* File: rtl/tcrb_consts.svh */
// Purpose: offsets, field positions, reset values and counts of the timer
// Assumes: register index times four gives the apb byte address
// Notes:   definitions only
`ifndef TCRB_CONSTS_SVH
`define TCRB_CONSTS_SVH

// ----------------------------------------------------------------------
// register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define TCRB_IDX_CTRL     8'hc8
`define TCRB_IDX_RLD_LO   8'hca
`define TCRB_IDX_RLD_HI   8'hcb
`define TCRB_IDX_CNT_LO   8'hcc
`define TCRB_IDX_CNT_HI   8'hcd
`define TCRB_IDX_IRQ_STAT 8'hc0
`define TCRB_IDX_IRQ_MASK 8'hc1

// ----------------------------------------------------------------------
// timer_ctrl field positions
// ----------------------------------------------------------------------
`define TCRB_B_OVF    7
`define TCRB_B_EXT    6
`define TCRB_B_RXSRC  5
`define TCRB_B_TXSRC  4
`define TCRB_B_TRIGEN 3
`define TCRB_B_RUN    2
`define TCRB_B_CSRC   1
`define TCRB_B_CAPSEL 0

// irq status / mask field positions
`define TCRB_I_OVF    0
`define TCRB_I_EXT    1

// ----------------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------------
`define TCRB_CTRL_RST 8'h00
`define TCRB_WORD_RST 16'h0000
`define TCRB_IRQ_RST  2'h0
`define TCRB_CNT_MAX  16'hffff
// system clocks per count step in timer mode
`define TCRB_TIMER_DIV 2

`endif

/* File: rtl/tcrb_pkg.sv */
// Purpose: state types of the timer block
// Assumes: nothing
// Notes:   constants live in tcrb_consts.svh
package tcrb_pkg;

	typedef struct packed {
		logic [7:0]  ctrl;
		logic [15:0] reload;
		logic [15:0] count;
		logic        prescale;
		logic [1:0]  irq_stat;
		logic [1:0]  irq_mask;
		logic        ack;
		logic [31:0] rdata;
		logic        slverr;
		logic        irq;
		logic        rx_tick;
		logic        tx_tick;
	} tcrb_state_t;

	// index 0: count pin, index 1: trigger pin
	typedef struct packed {
		logic [1:0] meta;
		logic [1:0] sync;
		logic [1:0] prev;
	} tcrb_sync_t;

endpackage

/* File: rtl/tcrb_edge_if.sv */
// Purpose: falling-edge pulses from the pin synchroniser to the timer
// Assumes: one clock domain
// Notes:   pulses last one cycle
`timescale 1ns/1ns
`default_nettype none

interface tcrb_edge_if;
	logic count_fall;
	logic trig_fall;
	modport src (output count_fall, output trig_fall);
	modport dst (input count_fall, input trig_fall);
endinterface

`default_nettype wire

/* File: rtl/tcrb_pin_sync.sv */
// Purpose: synchronise count and trigger pins, detect falling edges
// Assumes: pins are slow against pclk
// Notes:   edge seen two to three clocks after the pin falls
`timescale 1ns/1ns
`default_nettype none

module tcrb_pin_sync
	import tcrb_pkg::*;
(
	input  wire logic   pclk,
	input  wire logic   presetn,
	input  wire logic   count_input_pin,
	input  wire logic   trigger_pin,
	tcrb_edge_if.src    ev
);

	tcrb_sync_t s;
	tcrb_sync_t next_s;
	logic [1:0] fall;

	always_comb
	begin
		next_s      = s;
		next_s.meta = {trigger_pin, count_input_pin};
		next_s.sync = s.meta;
		next_s.prev = s.sync;
	end

	// idle high, so reset to high avoids a false edge
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			s <= '{meta: 2'h3, sync: 2'h3, prev: 2'h3};
		else
			s <= next_s;
	end

	genvar i;
	generate
		for (i = 0; i < 2; i++)
		begin : g_fall
			assign fall[i] = s.prev[i] & ~s.sync[i];
		end
	endgenerate

	assign ev.count_fall = fall[0];
	assign ev.trig_fall  = fall[1];

endmodule // tcrb_pin_sync

`default_nettype wire

/* File: tb/tcrb_far_end.sv */
// Purpose: pins and serial port side of the timer
// Assumes: pins idle high, timer1 overflow is a one-cycle pulse
// Notes:   counts baud ticks seen; tb calls its tasks
`timescale 1ns/1ns
`default_nettype none

module tcrb_far_end
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic rx_baud_tick,
	input  wire logic tx_baud_tick,
	output logic      count_input_pin,
	output logic      trigger_pin,
	output logic      timer1_overflow
);
	int rx_seen;
	int tx_seen;

	initial
	begin
		count_input_pin = 1'b1;
		trigger_pin = 1'b1;
		timer1_overflow = 1'b0;
	end

	always @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			rx_seen <= 0;
			tx_seen <= 0;
		end
		else
		begin
			rx_seen <= rx_seen + int'(rx_baud_tick);
			tx_seen <= tx_seen + int'(tx_baud_tick);
		end

	// levels held 3 clocks so the synchroniser sees each one
	task automatic falls(input logic trig, input int n);
		repeat (n)
		begin
			@(posedge pclk);
			if (trig)
				trigger_pin <= 1'b0;
			else
				count_input_pin <= 1'b0;
			repeat (3) @(posedge pclk);
			trigger_pin <= 1'b1;
			count_input_pin <= 1'b1;
			repeat (3) @(posedge pclk);
		end
	endtask

	task automatic t1_pulses(input int n);
		repeat (n)
		begin
			@(posedge pclk);
			timer1_overflow <= 1'b1;
			@(posedge pclk);
			timer1_overflow <= 1'b0;
			repeat (8) @(posedge pclk);
		end
	endtask
endmodule // tcrb_far_end

`default_nettype wire

/* File: tb/tb.sv */
// Purpose: register level tests of the timer over apb
// Assumes: pready comes back; only the watchdog ends a hung transfer
// Notes:   expected counts follow from the bus and prescaler timing
`timescale 1ns/1ns
`default_nettype none
`include "tcrb_consts.svh"

module tb;
	localparam logic [7:0] ctl = `TCRB_IDX_CTRL;
	localparam logic [7:0] rlo = `TCRB_IDX_RLD_LO;
	localparam logic [7:0] rhi = `TCRB_IDX_RLD_HI;
	localparam logic [7:0] clo = `TCRB_IDX_CNT_LO;
	localparam logic [7:0] chi = `TCRB_IDX_CNT_HI;
	localparam logic [7:0] ist = `TCRB_IDX_IRQ_STAT;
	localparam logic [7:0] imk = `TCRB_IDX_IRQ_MASK;
	logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rdat;
	logic        pready, pslverr, rerr, cpin, tpin, t1, rxt, txt, irq;
	int          num_errors = 0, checked = 0;

	tcrb_timer uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .count_input_pin(cpin), .trigger_pin(tpin),
		.timer1_overflow(t1), .rx_baud_tick(rxt), .tx_baud_tick(txt),
		.irq(irq));
	tcrb_far_end far (.pclk(pclk), .presetn(presetn), .rx_baud_tick(rxt),
		.tx_baud_tick(txt), .count_input_pin(cpin), .trigger_pin(tpin),
		.timer1_overflow(t1));

	initial
	begin
		forever #5 pclk = ~pclk;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic in_range(input logic [31:0] got, input int lo, hi);
		checked++;
		if ($isunknown(got) || got < lo || got > hi)
		begin
			num_errors++;
			$display("wrong value at %0t: %0d out of range", $time, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, i, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] i, input logic [31:0] d);
		apb(1'b1, i, d);
	endtask

	task automatic rc(input logic [7:0] i, input logic [31:0] e);
		apb(1'b0, i, 32'h0);
		check(rdat, e);
	endtask

	task automatic end_of_test;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		repeat (20000) @(posedge pclk);
		num_errors++;
		end_of_test;
	end

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rc(ctl, 32'h0);
		rc(rhi, 32'h0);
		rc(chi, 32'h0);
		rc(imk, 32'h0);
		apb(1'b0, 8'h10, 32'h0);
		check({31'h0, rerr}, 32'h1);
		wr(rlo, 32'ha5);
		rc(rlo, 32'ha5);
		$display("test registers done");
		wr(ctl, 32'h04);
		repeat (100) @(posedge pclk);
		wr(ctl, 32'h00);
		apb(1'b0, clo, 32'h0);
		check(rdat, 32'h34);
		wr(clo, 32'h42);
		repeat (20) @(posedge pclk);
		rc(clo, 32'h42);
		$display("test rate done");
		wr(clo, 32'hfe);
		wr(chi, 32'hff);
		wr(rlo, 32'h34);
		wr(rhi, 32'h12);
		wr(imk, 32'h1);
		wr(ctl, 32'h04);
		repeat (20) @(posedge pclk);
		rc(ctl, 32'h84);
		check({31'h0, irq}, 32'h1);
		rc(chi, 32'h12);
		wr(ctl, 32'h00);
		rc(ist, 32'h1);
		wr(ist, 32'h1);
		rc(ist, 32'h0);
		check({31'h0, irq}, 32'h0);
		$display("test overflow done");
		wr(rlo, 32'hf0);
		wr(rhi, 32'hff);
		wr(clo, 32'hf0);
		wr(chi, 32'hff);
		wr(ctl, 32'h2d);
		far.t1_pulses(5);
		far.falls(1'b1, 1);
		repeat (300) @(posedge pclk);
		rc(ctl, 32'h2d);
		rc(chi, 32'hff);
		rc(rlo, 32'hf0);
		wr(ctl, 32'h00);
		in_range(far.rx_seen, 9, 13);
		check(far.tx_seen, 32'h5);
		$display("test baud done");
		wr(ctl, 32'h14);
		far.t1_pulses(3);
		repeat (100) @(posedge pclk);
		rc(ctl, 32'h14);
		wr(ctl, 32'h00);
		check(far.rx_seen, 32'he);
		check(far.tx_seen, 32'h9);
		$display("test tx baud done");
		wr(clo, 32'h00);
		wr(chi, 32'h00);
		wr(ctl, 32'h06);
		far.falls(1'b0, 7);
		rc(clo, 32'h07);
		$display("test counter done");
		wr(clo, 32'h78);
		wr(chi, 32'h56);
		wr(imk, 32'h2);
		wr(ctl, 32'h0f);
		far.falls(1'b1, 1);
		rc(ctl, 32'h4f);
		rc(rlo, 32'h78);
		rc(rhi, 32'h56);
		check({31'h0, irq}, 32'h1);
		wr(imk, 32'h0);
		rc(ist, 32'h2);
		check({31'h0, irq}, 32'h0);
		$display("test capture done");
		wr(ctl, 32'h06);
		wr(clo, 32'h03);
		far.falls(1'b1, 1);
		rc(clo, 32'h03);
		wr(ctl, 32'h0e);
		far.falls(1'b1, 1);
		rc(clo, 32'h78);
		rc(ctl, 32'h4e);
		$display("test reload done");
		end_of_test;
	end
endmodule // tb

`default_nettype wire
